/* iord_map.vh */
// register offsets, field masks and access codes for the low i/o register space
`ifndef IORD_MAP_VH
`define IORD_MAP_VH
// access kinds issued by the core
`define IORD_OP_IN        3'h0
`define IORD_OP_OUT       3'h1
`define IORD_OP_LOAD      3'h2
`define IORD_OP_STORE     3'h3
`define IORD_OP_BSET      3'h4
`define IORD_OP_BCLR      3'h5
`define IORD_OP_SKIPSET   3'h6
`define IORD_OP_SKIPCLR   3'h7
// address space limits
`define IORD_IO_LAST      8'h3F
`define IORD_BIT_LAST     8'h1F
`define IORD_DATA_OFFSET  8'h20
`define IORD_EXT_FIRST    8'h60
// i/o offsets
`define IORD_PORT_A_INPUT_PINS         6'h00
`define IORD_PORT_A_DIRECTION         6'h01
`define IORD_PRTA         6'h02
`define IORD_PORT_B_INPUT_PINS         6'h03
`define IORD_PORT_B_DIRECTION         6'h04
`define IORD_PRTB         6'h05
`define IORD_PORT_C_INPUT_PINS         6'h06
`define IORD_PORT_C_DIRECTION         6'h07
`define IORD_PRTC         6'h08
`define IORD_PORT_D_INPUT_PINS         6'h09
`define IORD_PORT_D_DIRECTION         6'h0A
`define IORD_PRTD         6'h0B
`define IORD_TFLG0        6'h15
`define IORD_TFLG1        6'h16
`define IORD_TFLG2        6'h17
`define IORD_PCFLG        6'h1B
`define IORD_EXFLG        6'h1C
`define IORD_EXMSK        6'h1D
`define IORD_SCR0         6'h1E
`define IORD_EECTL        6'h1F
`define IORD_EEDAT        6'h20
`define IORD_EEADL        6'h21
`define IORD_EEADH        6'h22
`define IORD_GTPC         6'h23
`define IORD_T0CA         6'h24
`define IORD_T0CB         6'h25
`define IORD_T0CNT        6'h26
`define IORD_T0CMA        6'h27
`define IORD_T0CMB        6'h28
`define IORD_SCR1         6'h2A
`define IORD_SCR2         6'h2B
`define IORD_SPCTL        6'h2C
// implemented bit masks, reserved bits read zero
`define IORD_M_FULL       8'hFF
`define IORD_M_TFLG0      8'h07
`define IORD_M_TFLG1      8'h27
`define IORD_M_TFLG2      8'h07
`define IORD_M_PCFLG      8'h0F
`define IORD_M_EXFLG      8'h07
`define IORD_M_EXMSK      8'h07
`define IORD_M_EECTL      8'h3F
`define IORD_M_EEADH      8'h0F
`define IORD_M_GTPC       8'h83
`define IORD_M_T0CA       8'hF3
`define IORD_M_T0CB       8'hCF
// reset value of every register
`define IORD_RST          8'h00
`endif

/* iord_decode.v */
// low i/o register space: decode, bit access, skip test and flag clearing
`timescale 1ns/1ns
// Functional notes
// - in/out reach only i/o locations 0x00-0x3F
// - load/store see i/o registers at address plus 0x20
// - extended space 0x60 up only via load/store
// - bit set/clear works in 0x00-0x1F only
// - skip test of one bit in 0x00-0x1F
// - flags clear on writing one, zero ignored
// - bit set/clear rewrites whole register, clearing flags
//
// access protocol seen from the core
// - a request is taken on a rising edge with acc_valid high
// - only taken while the sequencer sits idle
// - a held request is therefore taken every other cycle
// - the answer flops change on the taken edge itself
// - acc_hit, acc_rdata and acc_skip stand for one cycle
// - in that same cycle the sequencer sits busy
// - a request raised in the busy cycle is simply ignored
// - the core must leave one idle cycle between requests
//
// address spaces
// - in/out use the raw six-bit i/o index
// - load/store see the same registers shifted up by 0x20
// - load/store at 0x60 and above leave this block via ext_sel
// - bit set, bit clear and skip tests reach 0x00-0x1F only
// - anything outside its window raises acc_error, no hit
//
// flags
// - flag locations ignore ordinary writes of zero bits
// - a one written to a flag bit clears that bit
// - bit set/clear rewrite the whole byte read back
// - so every flag seen as set is cleared by a bit set; a bit clear keeps the flag bit it names
// - a new event in the same cycle as a clear wins
//
// limitations
// - pin values lag the pins by three clocks
// - reserved locations are not stored, they read zero
// - no byte of the extended space is held here
`include "iord_map.vh"
module iord_decode #(
    parameter AW = 8                       // core-side address width
) (
    // clock and reset
    input  wire          ref_clk,
    input  wire          rst_n,
    // core access port
    input  wire          acc_valid,
    input  wire [2:0]    acc_op,
    input  wire [AW-1:0] acc_addr,
    input  wire [2:0]    acc_bit,
    input  wire [7:0]    acc_wdata,
    output reg  [7:0]    acc_rdata,
    output reg           acc_hit,
    output reg           acc_skip,
    output reg           ext_sel,
    output wire          acc_error,
    // port pins
    input  wire [31:0]   port_pins,
    output wire [31:0]   port_drive,
    output wire [31:0]   port_dir,
    // flag sources, one-cycle pulses
    input  wire [7:0]    tmr0_set,
    input  wire [7:0]    tmr1_set,
    input  wire [7:0]    tmr2_set,
    input  wire [7:0]    pcint_set,
    input  wire [7:0]    extint_set,
    // peripheral control outputs
    output wire [7:0]    ext_irq_mask,
    output wire [7:0]    eeprom_ctl,
    output wire [7:0]    eeprom_dat,
    output wire [15:0]   eeprom_adr,
    output wire [7:0]    prescaler_ctl,
    output wire [7:0]    tmr0_ctl_a,
    output wire [7:0]    tmr0_ctl_b,
    output wire [7:0]    tmr0_cnt,
    output wire [7:0]    tmr0_cmp_a,
    output wire [7:0]    tmr0_cmp_b,
    output wire [7:0]    spi_ctl
);

    // one-hot access states
    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    reg  [1:0]  state_reg;                 // access sequencer
    reg  [1:0]  state_next;
    reg  [7:0]  regs_reg [0:63];           // i/o array, 8 bits each
    reg  [31:0] pin_s1_reg;                // synchroniser stage one
    reg  [31:0] pin_s2_reg;                // synchroniser stage two
    reg  [7:0]  rd_mask;                   // implemented bits of addressed loc
    reg  [5:0]  io_idx;                    // decoded i/o index
    reg         io_ok;                     // address maps into i/o space
    reg  [7:0]  rd_val;                    // current value read
    reg  [7:0]  wr_val;                    // value to write back
    reg         wr_en;                     // write strobe
    reg         is_w1c;                    // location holds flags
    wire [7:0]  bit_sel;                   // one-hot bit of acc_bit
    wire [7:0]  data_idx;                  // data address less the i/o offset
    integer     i;

    assign bit_sel   = 8'h01 << acc_bit;
    assign data_idx  = acc_addr[7:0] - `IORD_DATA_OFFSET;
    assign acc_error = acc_valid & ~io_ok & ~ext_sel;

    // address translation per access kind
    // in/out: the low six address bits are the index, valid up to 0x3F
    // load/store: data addresses 0x20-0x5F fold onto the index
    // load/store: 0x60 and up is someone else's space
    // load/store: below 0x20 is the register file, not ours
    // bit and skip ops: index valid only up to 0x1F
    // io_ok low means nothing in the array is touched
    // ext_sel is combinational so the outer decode sees it at once
    // hazard: the subtraction is done at eight bits, then cut
    // to six, so 0x5F maps to 0x3F and never wraps below zero
    always @* begin
        io_idx  = 6'h00;
        io_ok   = 1'b0;
        ext_sel = 1'b0;
        case (acc_op)
            `IORD_OP_IN, `IORD_OP_OUT: begin
                io_ok  = (acc_addr[7:0] <= `IORD_IO_LAST);
                io_idx = acc_addr[5:0];
            end
            `IORD_OP_LOAD, `IORD_OP_STORE: begin
                if (acc_addr[7:0] >= `IORD_EXT_FIRST) begin
                    ext_sel = 1'b1;
                end else if (acc_addr[7:0] >= `IORD_DATA_OFFSET) begin
                    io_ok  = 1'b1;
                    io_idx = data_idx[5:0];
                end
            end
            default: begin
                io_ok  = (acc_addr[7:0] <= `IORD_BIT_LAST);
                io_idx = acc_addr[5:0];
            end
        endcase
    end

    // implemented bits per location
    // full bytes: ports, scratch, eeprom data/low addr, timer 0 count and compares, spi control
    // partial bytes: flags, masks, eeprom control and high addr, prescaler, timer 0 control a and b
    // reserved and absent locations get a zero mask
    // the mask gates both reads and ordinary writes
    // is_w1c marks the five flag locations
    // flag locations are written only by the clear logic below
    // hazard: a missing entry here silently reads as reserved
    always @* begin
        is_w1c = 1'b0;
        case (io_idx)
            `IORD_PORT_A_INPUT_PINS, `IORD_PORT_A_DIRECTION, `IORD_PRTA, `IORD_PORT_B_INPUT_PINS, `IORD_PORT_B_DIRECTION,
            `IORD_PRTB, `IORD_PORT_C_INPUT_PINS, `IORD_PORT_C_DIRECTION, `IORD_PRTC, `IORD_PORT_D_INPUT_PINS,
            `IORD_PORT_D_DIRECTION, `IORD_PRTD, `IORD_SCR0, `IORD_EEDAT, `IORD_EEADL,
            `IORD_T0CNT, `IORD_T0CMA, `IORD_T0CMB, `IORD_SCR1, `IORD_SCR2,
            `IORD_SPCTL: rd_mask = `IORD_M_FULL;
            `IORD_TFLG0: begin rd_mask = `IORD_M_TFLG0; is_w1c = 1'b1; end
            `IORD_TFLG1: begin rd_mask = `IORD_M_TFLG1; is_w1c = 1'b1; end
            `IORD_TFLG2: begin rd_mask = `IORD_M_TFLG2; is_w1c = 1'b1; end
            `IORD_PCFLG: begin rd_mask = `IORD_M_PCFLG; is_w1c = 1'b1; end
            `IORD_EXFLG: begin rd_mask = `IORD_M_EXFLG; is_w1c = 1'b1; end
            `IORD_EXMSK: rd_mask = `IORD_M_EXMSK;
            `IORD_EECTL: rd_mask = `IORD_M_EECTL;
            `IORD_EEADH: rd_mask = `IORD_M_EEADH;
            `IORD_GTPC:  rd_mask = `IORD_M_GTPC;
            `IORD_T0CA:  rd_mask = `IORD_M_T0CA;
            `IORD_T0CB:  rd_mask = `IORD_M_T0CB;
            default:     rd_mask = `IORD_RST;
        endcase
    end

    // read value and write-back value
    // rd_val is the masked content of the addressed location
    // out and store replace the byte with the core's data
    // bit set ors in one bit of the value read
    // bit clear ands out one bit of the value read
    // both bit ops write the whole byte back, flags included
    // skip tests and reads never raise the write strobe
    // nothing is written unless the request is taken now
    always @* begin
        rd_val = regs_reg[io_idx] & rd_mask;
        wr_val = rd_val;
        wr_en  = 1'b0;
        if (acc_valid && io_ok && state_reg == ST_IDLE) begin
            case (acc_op)
                `IORD_OP_OUT, `IORD_OP_STORE: begin
                    wr_en  = 1'b1;
                    wr_val = acc_wdata;
                end
                `IORD_OP_BSET: begin
                    wr_en  = 1'b1;
                    wr_val = rd_val | bit_sel;
                end
                `IORD_OP_BCLR: begin
                    wr_en  = 1'b1;
                    wr_val = rd_val & ~bit_sel;
                end
                default: wr_val = rd_val;
            endcase
        end
    end

    // sequencer: one access taken, then one answer cycle
    // idle: a valid request moves to busy
    // busy: always back to idle, the request is not looked at
    // this keeps a held acc_valid from being taken on two edges in a row
    // but one held past the busy cycle is taken again
    always @* begin
        case (state_reg)
            ST_IDLE: state_next = acc_valid ? ST_BUSY : ST_IDLE;
            ST_BUSY: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // pin synchroniser
    // pins are asynchronous to ref_clk
    // two flops per pin before any logic looks at them
    // only the second stage feeds the pin registers
    // costs latency, buys freedom from metastable reads
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 32'h00000000;
            pin_s2_reg <= 32'h00000000;
        end else begin
            pin_s1_reg <= port_pins;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // answer registers
    // hit: a taken request that mapped into the i/o array
    // rdata: value read by a taken in or load, else zero
    // skip: taken skip test whose bit matches, pre-write value
    // all three fall back to zero the cycle after
    // so the core may sample them without a strobe
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            acc_rdata <= `IORD_RST;
            acc_hit   <= 1'b0;
            acc_skip  <= 1'b0;
        end else begin
            state_reg <= state_next;
            acc_hit   <= acc_valid && io_ok && state_reg == ST_IDLE;
            acc_rdata <= (acc_valid && io_ok && state_reg == ST_IDLE &&
                          (acc_op == `IORD_OP_IN || acc_op == `IORD_OP_LOAD))
                         ? rd_val : `IORD_RST;
            acc_skip  <= acc_valid && io_ok && state_reg == ST_IDLE &&
                         ((acc_op == `IORD_OP_SKIPSET && rd_val[acc_bit]) ||
                          (acc_op == `IORD_OP_SKIPCLR && !rd_val[acc_bit]));
        end
    end

    // register array: writes, flag setting and w1c
    // ordinary locations take the masked write data
    // pin locations follow the synchronised pins every cycle
    // a write to a pin location is overridden, so it is read only
    // flag locations: clear the bits written as one
    // then or in the set pulses of this cycle
    // set pulses are masked to the implemented flag bits
    // hazard: set and clear in one cycle keeps the flag set
    // so an event is never lost to a late clear
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 64; i = i + 1) begin
                regs_reg[i] <= `IORD_RST;
            end
        end else begin
            // ordinary masked write, flags excluded
            if (wr_en && !is_w1c) begin
                regs_reg[io_idx] <= wr_val & rd_mask;
            end
            // pin inputs track synchronised pins
            regs_reg[`IORD_PORT_A_INPUT_PINS] <= pin_s2_reg[7:0];
            regs_reg[`IORD_PORT_B_INPUT_PINS] <= pin_s2_reg[15:8];
            regs_reg[`IORD_PORT_C_INPUT_PINS] <= pin_s2_reg[23:16];
            regs_reg[`IORD_PORT_D_INPUT_PINS] <= pin_s2_reg[31:24];
            // flags: write one clears, new event wins over clear
            regs_reg[`IORD_TFLG0] <= (((wr_en && io_idx == `IORD_TFLG0) ?
                (regs_reg[`IORD_TFLG0] & ~wr_val) : regs_reg[`IORD_TFLG0])
                | tmr0_set) & `IORD_M_TFLG0;
            regs_reg[`IORD_TFLG1] <= (((wr_en && io_idx == `IORD_TFLG1) ?
                (regs_reg[`IORD_TFLG1] & ~wr_val) : regs_reg[`IORD_TFLG1])
                | tmr1_set) & `IORD_M_TFLG1;
            regs_reg[`IORD_TFLG2] <= (((wr_en && io_idx == `IORD_TFLG2) ?
                (regs_reg[`IORD_TFLG2] & ~wr_val) : regs_reg[`IORD_TFLG2])
                | tmr2_set) & `IORD_M_TFLG2;
            regs_reg[`IORD_PCFLG] <= (((wr_en && io_idx == `IORD_PCFLG) ?
                (regs_reg[`IORD_PCFLG] & ~wr_val) : regs_reg[`IORD_PCFLG])
                | pcint_set) & `IORD_M_PCFLG;
            regs_reg[`IORD_EXFLG] <= (((wr_en && io_idx == `IORD_EXFLG) ?
                (regs_reg[`IORD_EXFLG] & ~wr_val) : regs_reg[`IORD_EXFLG])
                | extint_set) & `IORD_M_EXFLG;
        end
    end

    // control outputs straight from the array flops
    // no logic between flop and port, so no glitches leave
    // ports are packed d, c, b, a from msb to lsb
    // eeprom address is high byte over low byte
    assign port_drive    = {regs_reg[`IORD_PRTD], regs_reg[`IORD_PRTC],
                            regs_reg[`IORD_PRTB], regs_reg[`IORD_PRTA]};
    assign port_dir      = {regs_reg[`IORD_PORT_D_DIRECTION], regs_reg[`IORD_PORT_C_DIRECTION],
                            regs_reg[`IORD_PORT_B_DIRECTION], regs_reg[`IORD_PORT_A_DIRECTION]};
    assign ext_irq_mask  = regs_reg[`IORD_EXMSK];
    assign eeprom_ctl    = regs_reg[`IORD_EECTL];
    assign eeprom_dat    = regs_reg[`IORD_EEDAT];
    assign eeprom_adr    = {regs_reg[`IORD_EEADH], regs_reg[`IORD_EEADL]};
    assign prescaler_ctl = regs_reg[`IORD_GTPC];
    assign tmr0_ctl_a    = regs_reg[`IORD_T0CA];
    assign tmr0_ctl_b    = regs_reg[`IORD_T0CB];
    assign tmr0_cnt      = regs_reg[`IORD_T0CNT];
    assign tmr0_cmp_a    = regs_reg[`IORD_T0CMA];
    assign tmr0_cmp_b    = regs_reg[`IORD_T0CMB];
    assign spi_ctl       = regs_reg[`IORD_SPCTL];

endmodule // iord_decode

/* iord_decode_chk.sv */
// timing and mapping checks for the i/o register space decoder
`timescale 1ns/1ns
`include "iord_map.vh"
module iord_decode_chk #(
    parameter AW = 8
) (
    // clock and reset
    input wire          ref_clk,
    input wire          rst_n,
    // core side
    input wire          acc_valid,
    input wire [2:0]    acc_op,
    input wire [AW-1:0] acc_addr,
    input wire [7:0]    acc_wdata,
    input wire [7:0]    acc_rdata,
    input wire          acc_hit,
    input wire          acc_skip,
    input wire          ext_sel,
    input wire          acc_error,
    // register contents
    input wire [7:0]    ext_irq_mask,
    input wire [15:0]   eeprom_adr,
    input wire [7:0]    spi_ctl
);
    reg          took_reg;                 // request taken at last edge
    reg [2:0]    op_reg;                   // its access kind
    reg [AW-1:0] adr_reg;                  // its address
    reg [7:0]    wd_reg;                   // its write data
    wire         take = acc_valid & ~took_reg;
    // shadow of the one-cycle busy sequencer
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            took_reg <= 1'b0;
        end else begin
            took_reg <= take;
        end
    end
    // copy of the last request fields
    always @(posedge ref_clk) begin
        {op_reg, adr_reg, wd_reg} <= {acc_op, acc_addr, acc_wdata};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    hit_cause_a: assert property (acc_hit |-> took_reg)
        else $error("hit without a taken request");
    io_limit_a: assert property (take && acc_op[2:1] == 2'b00 && acc_addr > 8'h3F
        |-> acc_error ##1 !acc_hit) else $error("in/out above 0x3F accepted");
    low_data_a: assert property (take && acc_op[2:1] == 2'b01 && acc_addr < 8'h20
        |-> acc_error ##1 !acc_hit) else $error("data access below 0x20 accepted");
    store_map_a: assert property (took_reg && op_reg == `IORD_OP_STORE
        && adr_reg == 8'h4C |-> spi_ctl == wd_reg) else $error("store not mapped at +0x20");
    ext_route_a: assert property (acc_valid && acc_op[2:1] == 2'b01
        && acc_addr >= 8'h60 |-> ext_sel) else $error("extended address not routed");
    ext_block_a: assert property (acc_valid && acc_op[2:1] == 2'b00 |-> !ext_sel)
        else $error("in/out reached extended space");
    bit_limit_a: assert property (take && acc_op[2:1] == 2'b10 && acc_addr > 8'h1F
        |-> acc_error) else $error("bit op above 0x1F accepted");
    skip_cause_a: assert property (acc_skip |-> took_reg && op_reg[2:1] == 2'b11
        && adr_reg <= 8'h1F) else $error("skip without a low skip test");
    rdata_idle_a: assert property (acc_rdata != 8'h00 |-> took_reg
        && (op_reg == `IORD_OP_IN || op_reg == `IORD_OP_LOAD)) else $error("stray read data");
    mask_bits_a: assert property (took_reg && op_reg == `IORD_OP_OUT && adr_reg == 8'h1D
        |-> ext_irq_mask == (wd_reg & 8'h07)) else $error("mask register write wrong");
    resv_bits_a: assert property (eeprom_adr[15:12] == 4'h0 && ext_irq_mask[7:3] == 5'h00)
        else $error("reserved bits set");
endmodule // iord_decode_chk
bind iord_decode iord_decode_chk #(.AW(AW)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .acc_valid(acc_valid), .acc_op(acc_op), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_hit(acc_hit), .acc_skip(acc_skip), .ext_sel(ext_sel),
    .acc_error(acc_error), .ext_irq_mask(ext_irq_mask), .eeprom_adr(eeprom_adr),
    .spi_ctl(spi_ctl));

/* iord_core_model.sv */
// core model issuing single accesses to the decoder
`timescale 1ns/1ns
module iord_core_model (
    // clock
    input  wire        ref_clk,
    // request
    output logic       acc_valid,
    output logic [2:0] acc_op,
    output logic [7:0] acc_addr,
    output logic [2:0] acc_bit,
    output logic [7:0] acc_wdata,
    // answer
    input  wire  [7:0] acc_rdata,
    input  wire        acc_hit,
    input  wire        acc_skip
);
    int unsigned spacing = 0;              // extra idle cycles, slow core
    // idle bus at time zero
    initial begin
        {acc_valid, acc_op, acc_addr, acc_bit, acc_wdata} = 23'h0;
    end
    // one request, answer sampled in the cycle it stands
    task run(input [2:0] op, input [7:0] a, input [2:0] b, input [7:0] w,
             output [7:0] rd, output h, output s);
        repeat (spacing) @(posedge ref_clk);
        @(posedge ref_clk);
        {acc_valid, acc_op, acc_addr} <= {1'b1, op, a};
        {acc_bit, acc_wdata} <= {b, w};
        @(posedge ref_clk);
        acc_valid <= 1'b0;
        {acc_addr, acc_wdata} <= {~a, ~w}; // released lines toggle
        #1;
        {rd, h, s} = {acc_rdata, acc_hit, acc_skip};
    endtask
endmodule // iord_core_model

/* test_iord_decode.sv */
// self-checking bench for the i/o register space decoder
`timescale 1ns/1ns
`include "iord_map.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_iord_decode;
    logic        ref_clk, rst_n, h, s;
    logic [31:0] port_pins;
    logic [7:0]  t0, t1, t2, pc, ex, rd;
    wire         acc_valid, acc_hit, acc_skip, ext_sel, acc_error;
    wire  [2:0]  acc_op, acc_bit;
    wire  [7:0]  acc_addr, acc_wdata, acc_rdata, msk, ectl, edat, pre, ca, cb, cnt, cma, cmb, spi;
    wire  [15:0] eadr;
    wire  [31:0] drv, dir;
    int          bad_count, checked, cycles, i;
    // rw and reserved offsets with their implemented bits
    logic [7:0]  offs [25] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h1D,
        8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2A, 8'h2B,
        8'h2C, 8'h0C, 8'h18, 8'h29};
    logic [7:0]  bits [25] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07,
        8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h83, 8'hF3, 8'hCF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'h00, 8'h00, 8'h00};
    logic [7:0]  fa [5] = '{8'h15, 8'h16, 8'h17, 8'h1B, 8'h1C}; // flag offsets
    logic [7:0]  fm [5] = '{8'h07, 8'h27, 8'h07, 8'h0F, 8'h07}; // flag bits
    iord_core_model core (.ref_clk(ref_clk), .acc_valid(acc_valid), .acc_op(acc_op),
        .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata), .acc_hit(acc_hit), .acc_skip(acc_skip));
    iord_decode dut (.ref_clk(ref_clk), .rst_n(rst_n), .acc_valid(acc_valid), .acc_op(acc_op),
        .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_hit(acc_hit), .acc_skip(acc_skip), .ext_sel(ext_sel), .acc_error(acc_error),
        .port_pins(port_pins), .port_drive(drv), .port_dir(dir), .tmr0_set(t0), .tmr1_set(t1),
        .tmr2_set(t2), .pcint_set(pc), .extint_set(ex), .ext_irq_mask(msk), .eeprom_ctl(ectl),
        .eeprom_dat(edat), .eeprom_adr(eadr), .prescaler_ctl(pre), .tmr0_ctl_a(ca),
        .tmr0_ctl_b(cb), .tmr0_cnt(cnt), .tmr0_cmp_a(cma), .tmr0_cmp_b(cmb), .spi_ctl(spi));
    // free running clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    // one access through the core model
    task io(input [2:0] op, input [7:0] a, input [2:0] b, input [7:0] w);
        core.run(op, a, b, w, rd, h, s);
    endtask
    // verdict and end of run
    task print_verdict();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial begin
        {rst_n, t0, t1, t2, pc, ex} = 41'h0;
        port_pins = 32'hA5C35A3C;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 25; i++) begin
            io(`IORD_OP_IN, offs[i], 3'h0, 8'h00);
            `CHK("reset", 8'h00, rd)
            io(`IORD_OP_OUT, offs[i], 3'h0, 8'hFF);
            io(`IORD_OP_IN, offs[i], 3'h0, 8'h00);
            `CHK("bits", bits[i], rd)
        end
        `CHK("dir", 32'hFFFFFFFF, dir)
        `CHK("drive", 32'hFFFFFFFF, drv)
        io(`IORD_OP_OUT, 8'h1F, 3'h0, 8'hFF);
        `CHK("eectl", 8'h3F, ectl)
        `CHK("ctl", {8'h07, 8'hFF, 16'h0FFF, 8'h83, 8'hF3, 8'hCF}, {msk, edat, eadr, pre, ca, cb})
        `CHK("tmr0", 32'hFFFFFFFF, {cnt, cma, cmb, spi})
        io(`IORD_OP_OUT, 8'h00, 3'h0, 8'hFF);
        for (i = 0; i < 4; i++) begin
            io(`IORD_OP_IN, 8'(i * 3), 3'h0, 8'h00);
            `CHK("pins", port_pins[i*8+:8], rd)
        end
        io(`IORD_OP_STORE, 8'h3E, 3'h0, 8'h5A);
        io(`IORD_OP_IN, 8'h1E, 3'h0, 8'h00);
        `CHK("in", 8'h5A, rd)
        `CHK("hit", 1'b1, h)
        io(`IORD_OP_STORE, 8'h4C, 3'h0, 8'h3C);
        io(`IORD_OP_LOAD, 8'h4C, 3'h0, 8'h00);
        `CHK("load", 8'h3C, rd)
        io(`IORD_OP_IN, 8'h40, 3'h0, 8'h00);
        `CHK("io high", 1'b0, h)
        io(`IORD_OP_STORE, 8'h60, 3'h0, 8'h11);
        `CHK("ext", 1'b0, h)
        io(`IORD_OP_LOAD, 8'h10, 3'h0, 8'h00);
        `CHK("data low", 1'b0, h)
        io(`IORD_OP_BSET, 8'h1E, 3'h0, 8'h00);
        io(`IORD_OP_BCLR, 8'h1E, 3'h1, 8'h00);
        io(`IORD_OP_BCLR, 8'h2A, 3'h0, 8'h00);
        io(`IORD_OP_IN, 8'h1E, 3'h0, 8'h00);
        `CHK("bit ops", 8'h59, rd)
        io(`IORD_OP_IN, 8'h2A, 3'h0, 8'h00);
        `CHK("bit high", 8'hFF, rd)
        io(`IORD_OP_SKIPSET, 8'h1E, 3'h0, 8'h00);
        `CHK("skip set", 1'b1, s)
        io(`IORD_OP_SKIPCLR, 8'h1E, 3'h0, 8'h00);
        `CHK("skip clr", 1'b0, s)
        io(`IORD_OP_SKIPCLR, 8'h1E, 3'h1, 8'h00);
        `CHK("skip clr1", 1'b1, s)
        io(`IORD_OP_SKIPSET, 8'h2A, 3'h0, 8'h00);
        `CHK("skip high", 1'b0, s)
        core.spacing = 3;
        @(posedge ref_clk);
        {t0, t1, t2, pc, ex} <= {5{8'hFF}};
        @(posedge ref_clk);
        {t0, t1, t2, pc, ex} <= 40'h0;
        for (i = 0; i < 5; i++) begin
            io(`IORD_OP_IN, fa[i], 3'h0, 8'h00);
            `CHK("flags", fm[i], rd)
            io(`IORD_OP_OUT, fa[i], 3'h0, 8'h00);
            io(`IORD_OP_IN, fa[i], 3'h0, 8'h00);
            `CHK("zero write", fm[i], rd)
            io(`IORD_OP_OUT, fa[i], 3'h0, 8'h02);
            io(`IORD_OP_IN, fa[i], 3'h0, 8'h00);
            `CHK("one write", fm[i] & 8'hFD, rd)
            io(`IORD_OP_BSET, fa[i], 3'h3, 8'h00);
            io(`IORD_OP_IN, fa[i], 3'h0, 8'h00);
            `CHK("rmw clear", 8'h00, rd)
        end
        print_verdict();
    end
endmodule // test_iord_decode
